// ==== core/stc_pkg.sv ====
package stc_pkg;

    // =====================================================
    // Control register layout (bits 7:6 read as zero)
    // =====================================================
    localparam int CTRL_WIDTH = 6;
    localparam int POS_RUN_ENABLE = 0;
    localparam int POS_CLOCK_SOURCE_SELECT = 1;
    localparam int POS_SYNC_DISABLE = 2;
    localparam int POS_OSC_ENABLE = 3;
    localparam int POS_PRESCALE_LO = 4;
    localparam int POS_PRESCALE_HI = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [1:0] CTRL_UNUSED_READ = 2'h0;

    typedef struct packed {
        logic [1:0] prescale_select;
        logic osc_enable;
        logic sync_disable;
        logic clock_source_select;
        logic run_enable;
    } stc_ctrl_t;

    // =====================================================
    // Counting constants
    // =====================================================
    localparam int FOSC_DIVIDE = 4;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [1:0] PHASE_RESET = 2'h0;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_CLEAR = 16'h0000;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam int PRESCALE_BITS = 3;
    localparam logic [2:0] PRESCALE_CLEAR = 3'h0;
    localparam logic [3:0] CMP_MODE_SPECIAL_EVENT = 4'hb;
    localparam int OSC_MAX_KHZ = 200;

    // =====================================================
    // Special event trigger carrier from one compare unit
    // =====================================================
    typedef struct packed {
        logic [3:0] compare_mode_field;
        logic event_pulse;
    } stc_trig_t;

endpackage

// ==== core/stc_sync2.sv ====
`timescale 1ns/1ps
module stc_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // =====================================================
    // Two flops; only the second one is visible outside
    // =====================================================
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

// ==== core/stc_prescaler.sv ====
`timescale 1ns/1ps
module stc_prescaler (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic src_tick,
    input wire logic clear,
    input wire logic [1:0] prescale_select,
    output logic out_tick
);

    logic [stc_pkg::PRESCALE_BITS-1:0] div_reg;
    logic [stc_pkg::PRESCALE_BITS-1:0] mask;

    // =====================================================
    // Ratio 1:2^select; the last step of the ratio passes
    // =====================================================
    always_comb begin
        mask = 3'(({1'b0, 3'h7} >> (3 - prescale_select)) & 4'h7);
        out_tick = src_tick && ((div_reg & mask) == mask) && !clear;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b || clear) begin
            div_reg <= stc_pkg::PRESCALE_CLEAR;
        end else if (src_tick) begin
            div_reg <= 3'(div_reg + 3'h1);
        end
    end

    AST_PRESCALE_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_b)
        clear |=> div_reg == stc_pkg::PRESCALE_CLEAR)
        else $error("Prescaler not cleared by count write");

    AST_PRESCALE_ONE_TO_ONE: assert property (@(posedge core_clk) disable iff (!rst_b)
        (prescale_select == 2'h0 && src_tick && !clear) |-> out_tick)
        else $error("1:1 prescale dropped an input edge");

endmodule

// ==== core/stc_timer.sv ====
`timescale 1ns/1ps
module stc_timer (
    core_clk,
    rst_b,
    sleep_mode,
    ctrl_wr,
    ctrl_wdata,
    ctrl_rdata,
    count_low_wr,
    count_high_wr,
    count_wdata,
    count_low_byte,
    count_high_byte,
    osc_input_pin,
    ext_count_clock_pin,
    osc_amp_en,
    trig_one,
    trig_two,
    overflow_flag,
    wake_req,
    timebase_valid,
    timebase_count
);
    input wire logic core_clk;
    input wire logic rst_b;
    input wire logic sleep_mode;
    input wire logic ctrl_wr;
    input wire logic [7:0] ctrl_wdata;
    output logic [7:0] ctrl_rdata;
    input wire logic count_low_wr;
    input wire logic count_high_wr;
    input wire logic [7:0] count_wdata;
    output logic [7:0] count_low_byte;
    output logic [7:0] count_high_byte;
    input wire logic osc_input_pin;
    input wire logic ext_count_clock_pin;
    output logic osc_amp_en;
    input wire stc_pkg::stc_trig_t trig_one;
    input wire stc_pkg::stc_trig_t trig_two;
    output logic overflow_flag;
    output logic wake_req;
    output logic timebase_valid;
    output logic [15:0] timebase_count;

    // =====================================================
    // Control register
    // =====================================================
    stc_pkg::stc_ctrl_t ctrl_reg;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [1:0] phase_reg;
    logic [1:0] pin_sync;
    logic pin_last_reg;
    logic overflow_reg;
    logic wake_reg;

    logic async_mode;
    logic pin_level;
    logic pin_rise;
    logic fosc4_tick;
    logic src_tick;
    logic presc_tick;
    logic inc;
    logic any_wr;
    logic trig_hit;
    logic wrap;

    // Only a power-on/brown-out reset reaches this flop
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ctrl_reg <= stc_pkg::CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_reg <= ctrl_wdata[stc_pkg::CTRL_WIDTH-1:0];
        end
    end

    always_comb begin
        ctrl_rdata = {stc_pkg::CTRL_UNUSED_READ, ctrl_reg};
        osc_amp_en = ctrl_reg.osc_enable;
    end

    // =====================================================
    // Clock sources
    // =====================================================
    // Crystal and external pins are foreign to core_clk
    stc_sync2 #(
        .WIDTH(2)
    ) u_pin_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .async_in({osc_input_pin, ext_count_clock_pin}),
        .sync_out(pin_sync)
    );

    // Instruction clock is core_clk divided by four; it
    // stops in sleep like the oscillator that feeds it.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            phase_reg <= stc_pkg::PHASE_RESET;
        end else begin
            phase_reg <= 2'(phase_reg + 2'h1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pin_last_reg <= 1'b0;
        end else begin
            pin_last_reg <= pin_level;
        end
    end

    always_comb begin
        async_mode = ctrl_reg.clock_source_select && ctrl_reg.sync_disable;
        pin_level = ctrl_reg.osc_enable ? pin_sync[1] : pin_sync[0];
        pin_rise = pin_level && !pin_last_reg;
        fosc4_tick = (phase_reg == stc_pkg::PHASE_LAST) && !sleep_mode;
        if (ctrl_reg.clock_source_select) begin
            src_tick = pin_rise && ctrl_reg.run_enable;
        end else begin
            src_tick = fosc4_tick && ctrl_reg.run_enable;
        end
    end

    // =====================================================
    // Prescaler, then the synchronised increment
    // =====================================================
    stc_prescaler u_presc (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .src_tick(src_tick),
        .clear(any_wr),
        .prescale_select(ctrl_reg.prescale_select),
        .out_tick(presc_tick)
    );

    always_comb begin
        any_wr = count_low_wr || count_high_wr;
        // Prescaler keeps running in sleep in counter modes; only
        // the stage after it is gated in synchronised counter mode.
        inc = presc_tick && (async_mode || !sleep_mode || !ctrl_reg.clock_source_select);
        // Async mode ignores the trigger rather than risk it
        trig_hit = ((trig_one.event_pulse
                     && trig_one.compare_mode_field == stc_pkg::CMP_MODE_SPECIAL_EVENT)
                    || (trig_two.event_pulse
                     && trig_two.compare_mode_field == stc_pkg::CMP_MODE_SPECIAL_EVENT))
                   && !async_mode;
        wrap = inc && (count_reg == stc_pkg::COUNT_MAX);
    end

    // =====================================================
    // Count register pair
    // =====================================================
    always_comb begin
        count_next = count_reg;
        if (any_wr) begin
            if (count_low_wr) begin
                count_next[7:0] = count_wdata;
            end
            if (count_high_wr) begin
                count_next[15:8] = count_wdata;
            end
        end else if (trig_hit) begin
            count_next = stc_pkg::COUNT_CLEAR;
        end else if (inc) begin
            count_next = 16'(count_reg + stc_pkg::COUNT_ONE);
        end
    end

    // No reset term: the count survives every reset
    always_ff @(posedge core_clk) begin
        count_reg <= count_next;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            overflow_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            overflow_reg <= wrap && !any_wr && !trig_hit;
            wake_reg <= wrap && !any_wr && sleep_mode && async_mode;
        end
    end

    // Bytes come straight from core-domain flops, so a read
    // never sees a half-updated byte.
    always_comb begin
        count_low_byte = count_reg[7:0];
        count_high_byte = count_reg[15:8];
        overflow_flag = overflow_reg;
        wake_req = wake_reg;
        timebase_valid = !async_mode;
        timebase_count = async_mode ? stc_pkg::COUNT_CLEAR : count_reg;
    end

    // =====================================================
    // Assertions
    // =====================================================
    AST_TIMER_SPACING: assert property (@(posedge core_clk) disable iff (!rst_b)
        (inc && !ctrl_reg.clock_source_select && !ctrl_wr) |=> !inc [*3])
        else $error("Timer mode incremented faster than Fosc/4");

    AST_TIMER_SLEEP_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!ctrl_reg.clock_source_select && sleep_mode && !any_wr && !trig_hit) |=> $stable(count_reg))
        else $error("Timer mode moved during sleep");

    AST_PIN_EDGE_COUNT: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ctrl_reg.clock_source_select && ctrl_reg.run_enable && pin_rise && !sleep_mode
         && ctrl_reg.prescale_select == 2'h0 && !any_wr && !trig_hit)
        |=> count_reg == 16'($past(count_reg) + stc_pkg::COUNT_ONE))
        else $error("Pin rising edge not counted");

    AST_SYNC_SLEEP_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ctrl_reg.clock_source_select && !ctrl_reg.sync_disable && sleep_mode
         && !any_wr && !trig_hit) |=> $stable(count_reg))
        else $error("Synchronised counter moved during sleep");

    AST_ASYNC_SLEEP_COUNT: assert property (@(posedge core_clk) disable iff (!rst_b)
        (async_mode && sleep_mode && presc_tick && !any_wr)
        |=> count_reg == 16'($past(count_reg) + stc_pkg::COUNT_ONE))
        else $error("Async counter stopped in sleep");

    AST_WAKE_SOURCE: assert property (@(posedge core_clk) disable iff (!rst_b)
        wake_req |-> $past(async_mode) && $past(sleep_mode))
        else $error("Wake request outside async sleep");

    AST_NO_ASYNC_TIMEBASE: assert property (@(posedge core_clk) disable iff (!rst_b)
        async_mode |-> !timebase_valid && timebase_count == stc_pkg::COUNT_CLEAR)
        else $error("Async counter offered as timebase");

    AST_TIMEBASE_FOLLOWS: assert property (@(posedge core_clk) disable iff (!rst_b)
        !async_mode |-> timebase_valid && timebase_count == count_reg)
        else $error("Synchronous timebase does not follow the count");

    AST_OSC_ENABLE_FOLLOWS: assert property (@(posedge core_clk) disable iff (!rst_b)
        ctrl_wr |=> osc_amp_en == $past(ctrl_wdata[stc_pkg::POS_OSC_ENABLE]))
        else $error("Oscillator enable does not follow control write");

    AST_TRIG_CLEARS: assert property (@(posedge core_clk) disable iff (!rst_b)
        (trig_hit && !any_wr) |=> count_reg == stc_pkg::COUNT_CLEAR ##1 !overflow_flag)
        else $error("Special event did not clear count");

    AST_TRIG_NO_FLAG: assert property (@(posedge core_clk) disable iff (!rst_b)
        trig_hit |=> !overflow_flag)
        else $error("Special event raised overflow");

    AST_WRITE_WINS: assert property (@(posedge core_clk) disable iff (!rst_b)
        (count_low_wr && trig_hit) |=> count_low_byte == $past(count_wdata))
        else $error("Trigger overrode count write");

    AST_HIGH_WRITE_LANDS: assert property (@(posedge core_clk) disable iff (!rst_b)
        count_high_wr |=> count_high_byte == $past(count_wdata))
        else $error("High byte write lost");

    AST_CTRL_POR: assert property (@(posedge core_clk)
        !rst_b |=> ctrl_rdata == 8'h00)
        else $error("Control not cleared by power-on reset");

    AST_WRAP_FLAG: assert property (@(posedge core_clk) disable iff (!rst_b)
        (wrap && !any_wr && !trig_hit)
        |=> count_reg == stc_pkg::COUNT_CLEAR && overflow_flag)
        else $error("Wrap did not clear count and flag overflow");

    AST_STOPPED_HOLDS: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!ctrl_reg.run_enable && !any_wr && !trig_hit) |=> $stable(count_reg))
        else $error("Stopped timer moved");

    AST_ASYNC_TRIG_IGNORED: assert property (@(posedge core_clk) disable iff (!rst_b)
        (async_mode && (trig_one.event_pulse || trig_two.event_pulse) && !any_wr && !inc)
        |=> $stable(count_reg))
        else $error("Trigger acted in async mode");

    COV_WRAP: cover property (@(posedge core_clk) disable iff (!rst_b)
        overflow_flag);

    COV_TRIG_CLEAR: cover property (@(posedge core_clk) disable iff (!rst_b)
        trig_hit && !any_wr && count_reg != stc_pkg::COUNT_CLEAR);

    COV_ASYNC_WAKE: cover property (@(posedge core_clk) disable iff (!rst_b)
        wake_req);

    COV_WRITE_VS_TRIG: cover property (@(posedge core_clk) disable iff (!rst_b)
        any_wr && trig_hit);

    COV_ASYNC_TRIG: cover property (@(posedge core_clk) disable iff (!rst_b)
        async_mode && trig_one.event_pulse
        && trig_one.compare_mode_field == stc_pkg::CMP_MODE_SPECIAL_EVENT);

endmodule

// ==== bench/stc_clk_src.sv ====
`timescale 1ns/1ps
module stc_clk_src #(
    parameter int HALF_NS = 2500
) (
    input wire logic start,
    input wire logic use_osc,
    input wire logic [7:0] edges,
    output logic osc_input_pin,
    output logic ext_count_clock_pin
);
    // ==========================================
    // Burst source for the two count pins
    // ==========================================
    // Pins rest low between bursts, like a gated source
    initial begin
        osc_input_pin = 1'b0;
        ext_count_clock_pin = 1'b0;
    end

    // Half period of 2500 ns gives 200 kHz, the top crystal rate
    always @(posedge start) begin
        // Offset so no pin edge lands on a core clock edge
        #10;
        for (int i = 0; i < edges; i++) begin
            #(HALF_NS);
            if (use_osc) begin
                osc_input_pin = 1'b1;
            end else begin
                ext_count_clock_pin = 1'b1;
            end
            #(HALF_NS);
            osc_input_pin = 1'b0;
            ext_count_clock_pin = 1'b0;
        end
    end
endmodule

// ==== bench/sixteen_bit_timer_counter_tb.sv ====
`timescale 1ns/1ps
module sixteen_bit_timer_counter_tb;
    logic core_clk, rst_b, sleep_mode, ctrl_wr, count_low_wr, count_high_wr;
    logic [7:0] ctrl_wdata, count_wdata, ctrl_rdata, count_low_byte, count_high_byte, b;
    logic osc_input_pin, ext_count_clock_pin, osc_amp_en, overflow_flag, wake_req, timebase_valid;
    logic [15:0] timebase_count, mdl;
    logic src_start, src_osc;
    logic [7:0] src_edges;
    stc_pkg::stc_trig_t trig_one, trig_two;
    int errors, checks_done, ovf_n, wake_n;
    int seed = 32'h66bf;

    stc_timer i_dut (.core_clk(core_clk), .rst_b(rst_b), .sleep_mode(sleep_mode), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .count_low_wr(count_low_wr),
        .count_high_wr(count_high_wr), .count_wdata(count_wdata), .count_low_byte(count_low_byte),
        .count_high_byte(count_high_byte), .osc_input_pin(osc_input_pin),
        .ext_count_clock_pin(ext_count_clock_pin), .osc_amp_en(osc_amp_en), .trig_one(trig_one),
        .trig_two(trig_two), .overflow_flag(overflow_flag), .wake_req(wake_req),
        .timebase_valid(timebase_valid), .timebase_count(timebase_count));
    stc_clk_src i_src (.start(src_start), .use_osc(src_osc), .edges(src_edges),
        .osc_input_pin(osc_input_pin), .ext_count_clock_pin(ext_count_clock_pin));

    // ==========================================
    // Clock, pulse counters, watchdog
    // ==========================================
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Sampled on the rising edge so negedge clears in tasks never race
    always @(posedge core_clk) begin
        if (overflow_flag === 1'b1) ovf_n++;
        if (wake_req === 1'b1) wake_n++;
    end
    initial begin
        #(40 * 30000);
        errors++;
        print_verdict();
    end

    // ==========================================
    // Tasks
    // ==========================================
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wctrl(input logic [7:0] v);
        @(negedge core_clk);
        ctrl_wr = 1'b1;
        ctrl_wdata = v;
        @(negedge core_clk);
        ctrl_wr = 1'b0;
    endtask
    // Count write of the low byte, the high byte or both, optionally with a trigger pulse in the same cycle
    task automatic wcnt(input logic lo, input logic hi, input logic [7:0] v, input int tu,
        input logic [3:0] md);
        @(negedge core_clk);
        count_low_wr = lo;
        count_high_wr = hi;
        count_wdata = v;
        if (tu == 1) trig_one = {md, 1'b1};
        if (tu == 2) trig_two = {md, 1'b1};
        @(negedge core_clk);
        count_low_wr = 1'b0;
        count_high_wr = 1'b0;
        trig_one.event_pulse = 1'b0;
        trig_two.event_pulse = 1'b0;
        if (lo) mdl[7:0] = v;
        if (hi) mdl[15:8] = v;
    endtask
    task automatic burst(input logic osc, input int n);
        @(negedge core_clk);
        src_osc = osc;
        src_edges = n[7:0];
        src_start = 1'b1;
        repeat (n * 125 + 140) @(negedge core_clk);
        src_start = 1'b0;
    endtask
    task automatic done(input string nm);
        $display("test %s finished, errors so far %0d", nm, errors);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // Scenarios
    // ==========================================
    initial begin
        {rst_b, sleep_mode, ctrl_wr, count_low_wr, count_high_wr, src_start, src_osc} = 7'h00;
        {ctrl_wdata, count_wdata, src_edges, mdl} = 40'h0;
        trig_one = '0;
        trig_two = '0;
        repeat (10) @(negedge core_clk);
        rst_b = 1'b1;
        chk("ctrl_rdata", 16'h0000, {8'h00, ctrl_rdata});
        b = $random(seed);
        wctrl(b);
        chk("ctrl_rdata", {10'h000, b[5:0]}, {8'h00, ctrl_rdata});
        chk("osc_amp_en", {15'h0000, b[3]}, {15'h0000, osc_amp_en});
        wctrl(8'h30);
        // Stopped before writing, so split byte writes are safe
        wcnt(1'b1, 1'b0, $random(seed), 0, 4'h0);
        wcnt(1'b0, 1'b1, $random(seed), 0, 4'h0);
        rst_b = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_b = 1'b1;
        chk("count after reset", mdl, {count_high_byte, count_low_byte});
        chk("ctrl after reset", 16'h0000, {8'h00, ctrl_rdata});
        done("reset");
        for (int p = 0; p < 4; p++) begin
            wctrl({2'b00, p[1:0], 4'h1});
            wcnt(1'b1, 1'b1, $random(seed), 0, 4'h0);
            repeat (8 << p) @(negedge core_clk);
            mdl = mdl + 16'h0002;
            chk("timer count", mdl, {count_high_byte, count_low_byte});
        end
        wctrl(8'h01);
        ovf_n = 0;
        wake_n = 0;
        wcnt(1'b1, 1'b1, 8'hff, 0, 4'h0);
        repeat (8) @(negedge core_clk);
        chk("wrap count", 16'h0001, {count_high_byte, count_low_byte});
        chk("overflow pulses", 16'h0001, ovf_n[15:0]);
        chk("wake awake", 16'h0000, wake_n[15:0]);
        sleep_mode = 1'b1;
        wcnt(1'b1, 1'b1, 8'h42, 0, 4'h0);
        repeat (8) @(negedge core_clk);
        chk("timer asleep", mdl, {count_high_byte, count_low_byte});
        sleep_mode = 1'b0;
        done("timer");
        wctrl(8'h00);
        for (int u = 1; u < 3; u++) begin
            b = $random(seed);
            wcnt(1'b1, 1'b1, b, 0, 4'h0);
            wcnt(1'b0, 1'b0, b, u, (b[3:0] == 4'hb) ? 4'ha : b[3:0]);
            chk("other mode", mdl, {count_high_byte, count_low_byte});
            ovf_n = 0;
            wcnt(1'b0, 1'b0, b, u, stc_pkg::CMP_MODE_SPECIAL_EVENT);
            chk("event clear", 16'h0000, {count_high_byte, count_low_byte});
            chk("event ovf", 16'h0000, ovf_n[15:0]);
            wcnt(1'b1, 1'b1, b, u, stc_pkg::CMP_MODE_SPECIAL_EVENT);
            chk("write wins", mdl, {count_high_byte, count_low_byte});
        end
        done("trigger");
        for (int o = 0; o < 2; o++) begin
            wctrl({4'h0, o[0], 3'h3});
            if (o == 1) repeat (200) @(negedge core_clk);
            wcnt(1'b1, 1'b1, $random(seed), 0, 4'h0);
            burst(~o[0], 3);
            burst(o[0], 5);
            mdl = mdl + 16'h0005;
            chk("pin count", mdl, {count_high_byte, count_low_byte});
            chk("timebase", {15'h0000, 1'b1}, {15'h0000, timebase_valid});
            chk("timebase count", mdl, timebase_count);
        end
        wctrl(8'h13);
        wcnt(1'b1, 1'b1, $random(seed), 0, 4'h0);
        burst(1'b0, 6);
        mdl = mdl + 16'h0003;
        chk("pin prescaled", mdl, {count_high_byte, count_low_byte});
        sleep_mode = 1'b1;
        burst(1'b0, 3);
        chk("sync asleep", mdl, {count_high_byte, count_low_byte});
        sleep_mode = 1'b0;
        burst(1'b0, 1);
        mdl = mdl + 16'h0001;
        chk("prescaler ran asleep", mdl, {count_high_byte, count_low_byte});
        done("sync counter");
        wctrl(8'h07);
        chk("async timebase", 16'h0000, {15'h0000, timebase_valid});
        chk("async timebase count", 16'h0000, timebase_count);
        wcnt(1'b1, 1'b1, 8'hff, 0, 4'h0);
        sleep_mode = 1'b1;
        ovf_n = 0;
        wake_n = 0;
        burst(1'b0, 3);
        chk("async count", 16'h0002, {count_high_byte, count_low_byte});
        chk("async ovf", 16'h0001, ovf_n[15:0]);
        chk("async wake", 16'h0001, wake_n[15:0]);
        wcnt(1'b0, 1'b0, 8'h00, 1, stc_pkg::CMP_MODE_SPECIAL_EVENT);
        chk("async trigger", 16'h0002, {count_high_byte, count_low_byte});
        sleep_mode = 1'b0;
        done("async counter");
        print_verdict();
    end
endmodule
